// ---- design/lps_pkg.sv ----
// Purpose: Shared constants for the linear pixel scan sequencer and its controller
// Assumes: 20 MHz system clock, one clock domain
// Notes:   Times are kept in their own unit; settle time and link rates are turned into cycles here, exposure limits are not
package lps_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned NUM_POSITIONS  = 132;
  localparam int unsigned NUM_LEAD_DUMMY = 2;
  localparam int unsigned NUM_REAL       = 128;
  localparam int unsigned NUM_TAIL_DUMMY = 2;
  localparam int unsigned NUM_SCAN_CLKS  = 133;
  localparam int unsigned RESET_CLKS     = 18;
  localparam int unsigned POS_W          = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned SYS_PERIOD_NS  = 50;
  localparam int unsigned SETTLE_NS      = 10_000;
  localparam int unsigned SETTLE_CYCLES  = (SETTLE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned LINK_MIN_HZ    = 64_000;
  localparam int unsigned LINK_MAX_HZ    = 800_000;
  // Half period of the link clock in system cycles, 400 kHz default
  localparam int unsigned LINK_HALF_DEF  = 25;
  localparam int unsigned LINK_HALF_MIN  = (SYS_CLK_HZ / LINK_MAX_HZ + 1) / 2;
  localparam int unsigned LINK_HALF_MAX  = SYS_CLK_HZ / LINK_MIN_HZ / 2;
  localparam int unsigned EXPO_MIN_US_X8 = 1;    // 0.125 ms in 1/8 ms units
  localparam int unsigned EXPO_MAX_MS    = 100;
  localparam int unsigned EXPO_HOT_MS    = 2;
  localparam int unsigned EXPO_DEF_CYC   = 10_000;
  localparam int unsigned EXPO_W         = 24;
  localparam int unsigned DIV_W          = 16;
  localparam int unsigned SAMPLE_W       = 8;

endpackage

// ---- design/lps_link_if.sv ----
// Purpose: Pins between the pixel array and its controller
// Assumes: Both ends on one system clock; link clock is a sampled pin
// Notes:   Output enable active low
`timescale 1ns/10ps
interface lps_link_if;
  import lps_pkg::*;
  logic                startIn;
  logic                linkClk;
  logic [SAMPLE_W-1:0] pixelOut;
  logic                pixelOe_n;

  modport device (
    input  startIn,
    input  linkClk,
    output pixelOut,
    output pixelOe_n
  );
  modport controller (
    output startIn,
    output linkClk,
    input  pixelOut,
    input  pixelOe_n
  );
endinterface

// ---- design/lps_sync2.sv ----
// Purpose: Two-stage synchroniser for pins entering the system clock
// Assumes: Pin is asynchronous to clk
// Notes:   First stage feeds the second only
`timescale 1ns/10ps
module lps_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1  <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      stage1  <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule

// ---- design/lps_array_seq.sv ----
// Purpose: Digital sequencing of a 132-position linear photodiode array
// Assumes: Link pins sampled by clk; rising link edge is the capture edge
// Notes:   Analog values are modelled as per-pixel digital samples
`timescale 1ns/10ps
module lps_array_seq
  import lps_pkg::*;
#(
  parameter int unsigned POSITIONS = NUM_POSITIONS
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  lps_link_if.device                      link,
  input  wire logic [POSITIONS*SAMPLE_W-1:0] lightLevel,
  output logic                            integReset,
  output logic                            holdFrozen,
  output logic                            scanActive
);
  import lps_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic startSync;
  logic clkSync;
  logic clkLast;
  logic clkRise;

  lps_sync2 u_syncStart (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (link.startIn),
    .pinSync (startSync)
  );
  lps_sync2 u_syncClk (
    .clk     (clk),
    .rst_n   (rst_n),
    .pinIn   (link.linkClk),
    .pinSync (clkSync)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkLast <= 1'b0;
    end else begin
      clkLast <= clkSync;
    end
  end

  // Edge found on the synced copy, two sys clocks after the pin
  // Both pins see the same delay, so start and rise stay aligned
  assign clkRise = clkSync & ~clkLast;

  // ----------------------------------------------------------------
  // Shift register: bit k is output position k
  // ----------------------------------------------------------------
  logic [POSITIONS-1:0] shiftReg;
  logic                 lastBit;
  logic                 startCap;
  logic [POS_W-1:0]     resetCount;

  assign startCap = clkRise & startSync;

  // Rise after the last position reloads from position 0 only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= '0;
    end else if (clkRise && lastBit) begin
      shiftReg <= {{(POSITIONS-1){1'b0}}, startSync};
    end else if (clkRise) begin
      shiftReg <= {shiftReg[POSITIONS-2:0], startSync};
    end
  end

  // Flags the 133rd rise, which presents no pixel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastBit <= 1'b0;
    end else if (clkRise) begin
      lastBit <= shiftReg[POSITIONS-1] & ~lastBit;
    end
  end

  // ----------------------------------------------------------------
  // Integrator reset and hold control
  // ----------------------------------------------------------------
  // Integrator reset spans the capture rise plus 18 more rises
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      integReset <= 1'b0;
    end else if (startCap) begin
      integReset <= 1'b1;
    end else if (clkRise && resetCount == POS_W'(1)) begin
      integReset <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCount <= '0;
    end else if (startCap) begin
      resetCount <= POS_W'(RESET_CLKS);
    end else if (clkRise && resetCount != '0) begin
      resetCount <= resetCount - 1'b1;
    end
  end

  // Hold flag: frozen from start to end of integrator reset

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      holdFrozen <= 1'b0;
    end else if (startCap) begin
      holdFrozen <= 1'b1;
    end else if (clkRise && integReset && resetCount == POS_W'(1)) begin
      holdFrozen <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pixel cells: integrator and sampling capacitor per position
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] holdCap  [POSITIONS];
  logic [SAMPLE_W-1:0] integAcc [POSITIONS];
  logic                holdTrack;

  // Caps stay frozen until the scan has left the register,
  // so an unread position never picks up the next frame
  assign holdTrack = !holdFrozen && !startCap && (shiftReg == '0);

  for (genvar g = 0; g < POSITIONS; g++) begin : g_cell
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        integAcc[g] <= '0;
      end else if (integReset) begin
        integAcc[g] <= '0;
      end else begin
        integAcc[g] <= lightLevel[g*SAMPLE_W +: SAMPLE_W];
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        holdCap[g] <= '0;
      end else if (holdTrack) begin
        holdCap[g] <= integAcc[g];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  logic [SAMPLE_W-1:0] next_pixel;
  logic                anyPos;

  always_comb begin
    next_pixel = '0;
    for (int i = 0; i < POSITIONS; i++) begin
      if (shiftReg[i]) begin
        next_pixel = holdCap[i];
      end
    end
  end

  assign anyPos = |shiftReg;

  // Drive lags the shift by one sys clock; the controller
  // samples just before the next link rise, well after it settles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.pixelOut <= '0;
    end else begin
      link.pixelOut <= next_pixel;
    end
  end

  // Released once no position is left in the register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link.pixelOe_n <= 1'b1;
      scanActive     <= 1'b0;
    end else begin
      link.pixelOe_n <= ~anyPos;
      scanActive     <= anyPos | lastBit;
    end
  end

endmodule

// ---- design/lps_controller.sv ----
// Purpose: Controller that starts scans, makes the link clock and samples pixels
// Assumes: Same system clock as the array
// Notes:   First scan after reset is discarded
`timescale 1ns/10ps
module lps_controller
  import lps_pkg::*;
#(
  parameter int unsigned HALF_DIV = LINK_HALF_DEF
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  lps_link_if.controller           link,
  input  wire logic                scanReq,
  input  wire logic [EXPO_W-1:0]   exposureCycles,
  output logic [SAMPLE_W-1:0]      pixelData,
  output logic                     pixelValid,
  output logic                     frameDone,
  output logic                     busy
);
  import lps_pkg::*;

  typedef enum logic [2:0] {IDLE, START, SHIFT, SETTLE, WAITEXP} lps_ctl_t;
  lps_ctl_t state;
  logic [DIV_W-1:0]   divCnt;
  logic [POS_W-1:0]   clkNum;
  logic [EXPO_W-1:0]  waitCnt;
  logic               primed;
  logic               riseNow;
  logic               fallNow;
  logic [EXPO_W-1:0]  minExpo;

  // Settle plus (133-18) link periods
  assign minExpo = EXPO_W'(SETTLE_CYCLES) +
                   EXPO_W'((NUM_SCAN_CLKS - RESET_CLKS) * 2 * HALF_DIV);
  assign riseNow = (divCnt == DIV_W'(HALF_DIV - 1)) && !link.linkClk;
  assign fallNow = (divCnt == DIV_W'(HALF_DIV - 1)) && link.linkClk;

  // ----------------------------------------------------------------
  // Link clock divider, rate set by HALF_DIV with no clamp to the 64..800 kHz band
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt       <= '0;
      link.linkClk <= 1'b0;
    end else if (state == START || state == SHIFT) begin
      divCnt <= (divCnt == DIV_W'(HALF_DIV - 1)) ? '0 : divCnt + 1'b1;
      if (divCnt == DIV_W'(HALF_DIV - 1)) begin
        link.linkClk <= ~link.linkClk;
      end
    end else begin
      divCnt       <= '0;
      link.linkClk <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Scan sequence
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= IDLE;
      clkNum       <= '0;
      waitCnt      <= '0;
      primed       <= 1'b0;
      link.startIn <= 1'b0;
      frameDone    <= 1'b0;
      busy         <= 1'b0;
    end else begin
      frameDone <= 1'b0;
      case (state)
        IDLE: begin
          busy <= 1'b0;
          if (scanReq || !primed) begin
            state        <= START;
            link.startIn <= 1'b1;
            busy         <= 1'b1;
            clkNum       <= '0;
          end
        end
        START: begin
          if (fallNow) begin
            link.startIn <= 1'b0;
            state        <= SHIFT;
            clkNum       <= POS_W'(1);
          end
        end
        SHIFT: begin
          if (fallNow) begin
            clkNum <= clkNum + 1'b1;
            // Fall after the 133rd rise ends the burst
            if (clkNum == POS_W'(NUM_SCAN_CLKS - 1)) begin
              state   <= SETTLE;
              waitCnt <= '0;
            end
          end
        end
        SETTLE: begin
          waitCnt <= waitCnt + 1'b1;
          if (waitCnt >= EXPO_W'(SETTLE_CYCLES)) begin
            frameDone <= primed;
            primed    <= 1'b1;
            state     <= WAITEXP;
          end
        end
        WAITEXP: begin
          waitCnt <= waitCnt + 1'b1;
          if (waitCnt >= exposureCycles && waitCnt >= minExpo) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel sampling: keep real pixels only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pixelData  <= '0;
      pixelValid <= 1'b0;
    end else begin
      pixelValid <= 1'b0;
      if (riseNow && primed && (state == SHIFT) &&
          clkNum > POS_W'(NUM_LEAD_DUMMY) &&
          clkNum <= POS_W'(NUM_LEAD_DUMMY + NUM_REAL) && !link.pixelOe_n) begin
        pixelData  <= link.pixelOut;
        pixelValid <= 1'b1;
      end
    end
  end

endmodule

// ---- bench/lps_link_sva.sv ----
// Purpose: Wire checks on the link between array and controller
// Assumes: All link pins are flop outputs on clk
// Notes:   Rise count 1 is the start capture rise
`timescale 1ns/10ps
module lps_link_sva
  import lps_pkg::*;
(
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                startIn,
  input wire logic                linkClk,
  input wire logic [SAMPLE_W-1:0] pixelOut,
  input wire logic                pixelOe_n
);
  localparam int MINP = SYS_CLK_HZ / LINK_MAX_HZ - 1;
  localparam int MAXP = SYS_CLK_HZ / LINK_MIN_HZ - 1;
  logic       prevClk;
  logic       lastStart;
  logic       linkRise;
  logic [7:0] riseCnt;
  logic [9:0] sinceRise;

  assign linkRise = linkClk & ~prevClk;

  // ----------------------------------------------------------------
  // Link edge tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClk   <= 1'b0;
      lastStart <= 1'b0;
    end else begin
      prevClk <= linkClk;
      if (linkRise) lastStart <= startIn;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) riseCnt <= 8'h00;
    else if (linkRise && startIn) riseCnt <= 8'h01;
    else if (linkRise && riseCnt != 8'h00 && riseCnt < 8'h85) riseCnt <= riseCnt + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sinceRise <= 10'h000;
    else if (linkRise) sinceRise <= 10'h000;
    else if (sinceRise != 10'h3FF) sinceRise <= sinceRise + 10'h001;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_CAPTURE_DRIVES: assert property (linkRise && startIn |-> ##[1:8] !pixelOe_n)
    else $error("Output not driven after start capture");
  AST_FIRST_POSITION: assert property ($fell(pixelOe_n) |-> riseCnt == 8'h01)
    else $error("Output enabled away from capture rise");
  AST_DRIVEN_IN_SCAN: assert property (riseCnt inside {[8'h01:8'h84]} && sinceRise > 10'h008
    |-> !pixelOe_n)
    else $error("Output released inside the scan");
  AST_LAST_RISE_FREES: assert property ($rose(pixelOe_n) |-> riseCnt == 8'h85)
    else $error("Output released on wrong rise");
  AST_RELEASED_IDLE: assert property ((riseCnt == 8'h85 || riseCnt == 8'h00)
    && sinceRise > 10'h008 |-> pixelOe_n)
    else $error("Output driven outside a scan");
  AST_OUT_ON_RISE: assert property (!pixelOe_n && !$stable(pixelOut) |-> sinceRise <= 10'h008)
    else $error("Pixel changed away from a link rise");
  AST_SINGLE_START: assert property (linkRise && startIn |-> !lastStart)
    else $error("Start seen on two rises");
  AST_SETTLE_GAP: assert property ($rose(startIn) && riseCnt == 8'h85
    |-> sinceRise >= SETTLE_CYCLES)
    else $error("Start too soon after last rise");
  AST_LINK_RATE: assert property (linkRise && riseCnt inside {[8'h01:8'h84]}
    |-> sinceRise >= MINP && sinceRise <= MAXP)
    else $error("Link clock period out of range");
endmodule

// ---- bench/tb_linear_pixel_scan_sequencer.sv ----
// Purpose: Bench for the array sequencer facing its controller
// Assumes: 20 MHz clk, fast link divider
// Notes:   Pixel value is position xor a frame key
`timescale 1ns/10ps
module tb_linear_pixel_scan_sequencer;
  import lps_pkg::*;
  localparam int HDIV = 13;
  localparam int P    = 2 * HDIV;
  localparam int GAP  = 112 * P;
  logic                              clk;
  logic                              rst_n;
  logic                              scanReq;
  logic [EXPO_W-1:0]                 exposureCycles;
  logic [NUM_POSITIONS*SAMPLE_W-1:0] lightLevel;
  logic                              integReset;
  logic                              holdFrozen;
  logic                              scanActive;
  logic [SAMPLE_W-1:0]               pixelData;
  logic                              pixelValid;
  logic                              frameDone;
  logic                              busy;
  logic                              prevLink;
  logic                              prevIr;
  logic                              prevSi;
  logic [SAMPLE_W-1:0]               got [$];
  int                                mismatches;
  int                                checkCount;
  int                                frames;
  int                                irCnt;
  int                                hfCnt;
  int                                cyc;
  int                                irFall;
  int                                gap;
  int                                f0;

  lps_link_if link ();
  lps_array_seq u_lps_array_seq (.clk(clk), .rst_n(rst_n), .link(link),
    .lightLevel(lightLevel), .integReset(integReset), .holdFrozen(holdFrozen),
    .scanActive(scanActive));
  lps_controller #(.HALF_DIV(HDIV)) u_lps_controller (.clk(clk), .rst_n(rst_n),
    .link(link), .scanReq(scanReq), .exposureCycles(exposureCycles),
    .pixelData(pixelData), .pixelValid(pixelValid), .frameDone(frameDone), .busy(busy));
  lps_link_sva u_lps_link_sva (.clk(clk), .rst_n(rst_n), .startIn(link.startIn),
    .linkClk(link.linkClk), .pixelOut(link.pixelOut), .pixelOe_n(link.pixelOe_n));

  always #25 clk = ~clk;

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prevLink <= link.linkClk;
    prevIr <= integReset;
    prevSi <= link.startIn;
    if (pixelValid === 1'b1) got.push_back(pixelData);
    if (frameDone === 1'b1) frames <= frames + 1;
    if (link.linkClk === 1'b1 && prevLink === 1'b0) begin
      irCnt <= irCnt + int'(integReset === 1'b1);
      hfCnt <= hfCnt + int'(holdFrozen === 1'b1);
    end
    if (prevIr === 1'b1 && integReset === 1'b0) irFall <= cyc;
    if (link.startIn === 1'b1 && prevSi === 1'b0) gap <= cyc - irFall;
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic halt(input string m);
    mismatches++;
    $display("MISMATCH %0t timeout %s", $time, m);
    print_verdict();
  endtask

  task automatic setLight(input logic [7:0] key);
    for (int p = 1; p <= NUM_POSITIONS; p++) begin
      lightLevel[(p-1)*SAMPLE_W +: SAMPLE_W] = p[7:0] ^ key;
    end
  endtask

  task automatic waitIr();
    int n;
    for (n = 0; n < 400 && integReset !== 1'b1; n++) @(negedge clk);
    if (n == 400) halt("start");
  endtask

  task automatic waitDone(input int f);
    int n;
    for (n = 0; n < 20000 && !(frames == f && busy === 1'b0); n++) @(negedge clk);
    if (n == 20000) halt("frame");
  endtask

  // Light changes once the frame is frozen
  task automatic runFrame(input logic [EXPO_W-1:0] e, input logic [7:0] key,
                          input logic [7:0] nextKey, input int minGap);
    int f;
    f = frames;
    got.delete();
    irCnt = 0;
    hfCnt = 0;
    exposureCycles = e;
    scanReq = 1'b1;
    waitIr();
    scanReq = 1'b0;
    setLight(nextKey);
    waitDone(f + 1);
    cmp(frames, f + 1, "frames");
    cmp(got.size(), NUM_REAL, "samples");
    for (int n = 0; n < got.size(); n++) begin
      cmp(got[n], (n + 3) ^ key, "pixel");
    end
    cmp(irCnt, RESET_CLKS, "reset rises");
    cmp(hfCnt, RESET_CLKS, "hold rises");
    cmp(gap >= minGap, 1'b1, "exposure");
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    scanReq = 1'b0;
    exposureCycles = 24'h000010;
    setLight(8'h00);
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    waitDone(0);
    cmp(got.size(), 0, "priming samples");
    runFrame(24'h000010, 8'h00, 8'h5A, GAP + SETTLE_CYCLES);
    runFrame(24'h001000, 8'h5A, 8'hC3, GAP + SETTLE_CYCLES);
    runFrame(24'h000010, 8'hC3, 8'h3C, GAP + 24'h001000);
    scanReq = 1'b1;
    waitIr();
    rst_n = 1'b0;
    scanReq = 1'b0;
    @(negedge clk);
    cmp(link.pixelOe_n, 1'b1, "oe in reset");
    cmp(integReset, 1'b0, "integ in reset");
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    f0 = frames;
    got.delete();
    repeat (4) @(negedge clk);
    waitDone(f0);
    cmp(got.size(), 0, "reprime samples");
    runFrame(24'h000010, 8'h3C, 8'h00, GAP + SETTLE_CYCLES);
    print_verdict();
  end
endmodule
